// >>> tb_vectored_irq_handler.sv
// self-checking bench for the vectored interrupt handler
`timescale 1ns/1ps
module tb_vectored_irq_handler import vih_pkg::*;;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	vih_src_t src_event = '0;
	logic return_from_isr_instr_cmd = 1'b0;
	logic [7:0] reg_rdata, taken_cnt;
	logic instr_done, irq_ack, return_from_isr_instr_done, irq_req;
	logic [15:0] irq_vector, taken_vec;
	logic [4:0] irq_src, taken_src;
	int num_errors = 0;
	int checks = 0;
	always #5 ref_clk = ~ref_clk;
	vih_handler vih_handler_inst (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.src_event, .instr_done, .irq_ack, .return_from_isr_instr_done, .irq_req, .irq_vector, .irq_src);
	vih_core_model vih_core_model_inst (.ref_clk, .srst, .irq_req, .irq_vector, .irq_src, .return_from_isr_instr_cmd,
		.instr_done, .irq_ack, .return_from_isr_instr_done, .taken_vec, .taken_src, .taken_cnt);
	// ***************************************************
	// access and check tasks
	// ***************************************************
	task automatic wrap_up();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string name, logic [15:0] exp, logic [15:0] seen);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a, logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask
	// global enable goes last so a request cannot start in mid-update
	task automatic set_en(logic glob, vih_src_t m);
		wr(4'h1, m[14:7]);
		wr(4'h2, {4'h0, m[18:15]});
		wr(4'h0, {glob, m[6:0]});
	endtask
	task automatic pend(vih_src_t m);
		rd(4'h6, m[7:0]);
		rd(4'h7, m[15:8]);
		rd(4'h8, {5'h00, m[18:16]});
	endtask
	task automatic clr();
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h00);
		wr(4'h8, 8'h00);
	endtask
	task automatic ev(vih_src_t m);
		@(posedge ref_clk);
		src_event <= m;
		@(posedge ref_clk);
		src_event <= '0;
	endtask
	task automatic return_from_isr_instr();
		@(posedge ref_clk);
		return_from_isr_instr_cmd <= 1'b1;
		@(posedge ref_clk);
		return_from_isr_instr_cmd <= 1'b0;
	endtask
	task automatic quiet(int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			chk("irq_req", 16'h0000, {15'h0000, irq_req});
		end
	endtask
	// bounded wait for the next call, then source and vector
	task automatic take(logic [4:0] s);
		logic [7:0] old;
		old = taken_cnt;
		for (int n = 0; n < 40 && taken_cnt === old; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (taken_cnt === old) begin
			num_errors++;
			wrap_up();
		end else begin
			chk("irq_src", {11'h000, s}, {11'h000, taken_src});
			chk("irq_vector", 16'h0003 + 16'h0008 * {11'h000, s}, taken_vec);
		end
	endtask
	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		chk("irq_vector", 16'h0003, irq_vector);
		wr(4'hf, 8'hff);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 8'h00);
		// held while globally off, then serviced; re-entry while still set
		set_en(1'b0, 19'h00020);
		ev(19'h00020);
		quiet(10);
		pend(19'h00020);
		set_en(1'b1, 19'h00000);
		quiet(6);
		set_en(1'b1, 19'h00020);
		take(5'd5);
		return_from_isr_instr();
		take(5'd5);
		clr();
		return_from_isr_instr();
		quiet(10);
		// software-set flag acts as a real event
		set_en(1'b1, 19'h00200);
		wr(4'h7, 8'h02);
		take(5'd9);
		clr();
		return_from_isr_instr();
		// every source on its own; only sources 0..3 clear in hardware
		for (int i = 0; i < 19; i++) begin
			set_en(1'b1, 19'h00001 << i);
			ev(19'h00001 << i);
			take(i[4:0]);
			pend(i < 4 ? 19'h00000 : 19'h00001 << i);
			clr();
			return_from_isr_instr();
		end
		// same level: fixed order; then high level first and preemption
		set_en(1'b1, 19'h00012);
		ev(19'h00012);
		take(5'd1);
		quiet(8);
		return_from_isr_instr();
		take(5'd4);
		clr();
		return_from_isr_instr();
		wr(4'h3, 8'h10);
		ev(19'h00012);
		take(5'd4);
		quiet(8);
		wr(4'h6, 8'h02);
		return_from_isr_instr();
		take(5'd1);
		ev(19'h00010);
		take(5'd4);
		rd(4'h9, 8'h0c);
		clr();
		return_from_isr_instr();
		return_from_isr_instr();
		quiet(10);
		wrap_up();
	end
endmodule // tb_vectored_irq_handler

// >>> vih_cfg.svh
// constants for the vectored interrupt handler: offsets, fields, reset values and timing
`ifndef VIH_CFG_SVH
`define VIH_CFG_SVH

// ***************************************************
// register offsets on the plain port
// ***************************************************
`define VIH_OFS_BASIC_EN 4'h0
`define VIH_OFS_EXT_EN1 4'h1
`define VIH_OFS_EXT_EN2 4'h2
`define VIH_OFS_PRIO 4'h3
`define VIH_OFS_EXT_PRIO1 4'h4
`define VIH_OFS_EXT_PRIO2 4'h5
`define VIH_OFS_PEND_LO 4'h6
`define VIH_OFS_PEND_MID 4'h7
`define VIH_OFS_PEND_HI 4'h8
`define VIH_OFS_STATUS 4'h9

// ***************************************************
// fields and reset values
// ***************************************************
`define VIH_GLOBAL_EN_BIT 7
`define VIH_EN_RST 8'h00
`define VIH_PRIO_RST 8'h00
`define VIH_NSRC 19
`define VIH_VEC_BASE 16'h0003
`define VIH_VEC_STEP 16'h0008

// ***************************************************
// timing
// ***************************************************
`define VIH_CLK_NS 10
`define VIH_MIN_RESP_CYC 7
`define VIH_MAX_RESP_CYC 19

`endif

// >>> vih_core_model.sv
// core-side model: instruction pacing, call acknowledge and return pulses
`timescale 1ns/1ps
// ***************************************************
// core model
// ***************************************************
module vih_core_model (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic [4:0] irq_src,
	input wire logic return_from_isr_instr_cmd,
	output logic instr_done,
	output logic irq_ack,
	output logic return_from_isr_instr_done,
	output logic [15:0] taken_vec,
	output logic [4:0] taken_src,
	output logic [7:0] taken_cnt
);
	// an instruction ends every other cycle; the call is only taken at such an end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			instr_done <= 1'b0;
			irq_ack <= 1'b0;
			return_from_isr_instr_done <= 1'b0;
		end else begin
			instr_done <= ~instr_done;
			irq_ack <= irq_req & ~instr_done & ~irq_ack;
			return_from_isr_instr_done <= return_from_isr_instr_cmd;
		end
	end
	// latch what the call fetched; an ack without a request is ignored
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			taken_cnt <= 8'h00;
			taken_vec <= 16'h0000;
			taken_src <= 5'h00;
		end else if (irq_ack & irq_req) begin
			taken_cnt <= taken_cnt + 8'h01;
			taken_vec <= irq_vector;
			taken_src <= irq_src;
		end
	end
endmodule // vih_core_model

// >>> vih_handler.sv
// vectored interrupt handler: pending flags, enables, priority and call sequencing
`timescale 1ns/1ps
`include "vih_cfg.svh"
module vih_handler import vih_pkg::*; (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [18:0] src_event,
	input wire logic instr_done,
	input wire logic irq_ack,
	input wire logic return_from_isr_instr_done,
	output logic irq_req,
	output logic [15:0] irq_vector,
	output logic [4:0] irq_src
);
	// sources that clear their flag in hardware on the call: both externals and timers 0/1
	localparam vih_src_t HW_CLR = 19'h0000f;

	logic [7:0] basic_irq_enable_reg;
	logic [7:0] ext_en1;
	logic [7:0] ext_en2;
	logic [7:0] prio_reg;
	logic [7:0] ext_prio1;
	logic [7:0] ext_prio2;
	vih_src_t pend;
	vih_src_t next_pend;
	vih_src_t src_en;
	vih_src_t src_hi;
	vih_src_t live;
	vih_src_t sw_set;
	vih_src_t sw_clr;
	logic global_irq_enable;
	logic cand_ok;
	logic cand_hi;
	vih_idx_t cand_idx;
	vih_seq_e seq;
	vih_seq_e next_seq;
	vih_idx_t held_idx;
	logic held_hi;
	logic call_taken;
	vih_lvl_if lv ();

	// ***************************************************
	// helpers
	// ***************************************************
	// lowest set index wins: this is the fixed source order
	function automatic vih_idx_t first_set(input vih_src_t v);
		vih_idx_t r;
		r = 5'h00;
		for (int i = `VIH_NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] vec_of(input vih_idx_t i);
		return 16'(`VIH_VEC_BASE + `VIH_VEC_STEP * 16'(i));
	endfunction

	function automatic vih_src_t onehot(input vih_idx_t i);
		return vih_src_t'(19'h00001 << i);
	endfunction

	vih_lvl_stack u_stack (
		.ref_clk(ref_clk),
		.srst(srst),
		.lv(lv)
	);

	// ***************************************************
	// configuration registers
	// ***************************************************
	// one enable per source across basic and extended registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			basic_irq_enable_reg <= `VIH_EN_RST;
			ext_en1 <= `VIH_EN_RST;
			ext_en2 <= `VIH_EN_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`VIH_OFS_BASIC_EN: basic_irq_enable_reg <= reg_wdata;
				`VIH_OFS_EXT_EN1: ext_en1 <= reg_wdata;
				`VIH_OFS_EXT_EN2: ext_en2 <= reg_wdata;
				default: ;
			endcase
		end
	end

	// priority bits reset to low level
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prio_reg <= `VIH_PRIO_RST;
			ext_prio1 <= `VIH_PRIO_RST;
			ext_prio2 <= `VIH_PRIO_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`VIH_OFS_PRIO: prio_reg <= reg_wdata;
				`VIH_OFS_EXT_PRIO1: ext_prio1 <= reg_wdata;
				`VIH_OFS_EXT_PRIO2: ext_prio2 <= reg_wdata;
				default: ;
			endcase
		end
	end

	assign global_irq_enable = basic_irq_enable_reg[`VIH_GLOBAL_EN_BIT];
	assign src_en = {ext_en2[3:0], ext_en1, basic_irq_enable_reg[6:0]};
	assign src_hi = {ext_prio2[3:0], ext_prio1, prio_reg[6:0]};

	// ***************************************************
	// pending flags
	// ***************************************************
	// software writes both set (simulated interrupt) and clear a flag
	always_comb begin
		sw_set = '0;
		sw_clr = '0;
		if (reg_wr) begin
			case (reg_addr)
				`VIH_OFS_PEND_LO: begin
					sw_set[7:0] = reg_wdata;
					sw_clr[7:0] = ~reg_wdata;
				end
				`VIH_OFS_PEND_MID: begin
					sw_set[15:8] = reg_wdata;
					sw_clr[15:8] = ~reg_wdata;
				end
				`VIH_OFS_PEND_HI: begin
					sw_set[18:16] = reg_wdata[2:0];
					sw_clr[18:16] = ~reg_wdata[2:0];
				end
				default: ;
			endcase
		end
	end

	// events set flags regardless of enables; a set beats any clear in the same cycle
	always_comb begin
		next_pend = pend & ~sw_clr;
		if (call_taken) begin
			next_pend = next_pend & ~(HW_CLR & onehot(held_idx));
		end
		next_pend = next_pend | src_event | sw_set;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend <= '0;
		end else begin
			pend <= next_pend;
		end
	end

	// ***************************************************
	// priority decode, every cycle
	// ***************************************************
	// global low masks everything, but flags stay pending
	assign live = global_irq_enable ? (pend & src_en) : '0;

	// high level wins over low; within a level lowest index; only preemptable levels allowed
	always_comb begin
		cand_hi = |(live & src_hi);
		cand_idx = cand_hi ? first_set(live & src_hi) : first_set(live);
		if (lv.in_high) begin
			cand_ok = 1'b0;
		end else if (lv.in_low) begin
			cand_ok = cand_hi;
		end else begin
			cand_ok = |live;
		end
	end

	// ***************************************************
	// call sequencing
	// ***************************************************
	// after a return one more instruction must complete before the next call
	always_comb begin
		next_seq = seq;
		case (seq)
			VIH_IDLE: begin
				if (return_from_isr_instr_done) begin
					next_seq = VIH_WAIT_ONE;
				end else if (cand_ok) begin
					next_seq = VIH_REQ;
				end
			end
			VIH_REQ: begin
				if (call_taken) begin
					next_seq = VIH_IDLE;
				end else if (return_from_isr_instr_done) begin
					next_seq = VIH_WAIT_ONE;
				end else if (!cand_ok) begin
					next_seq = VIH_IDLE;
				end
			end
			VIH_WAIT_ONE: begin
				if (instr_done && !return_from_isr_instr_done) begin
					next_seq = VIH_IDLE;
				end
			end
			default: next_seq = VIH_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			seq <= VIH_IDLE;
		end else begin
			seq <= next_seq;
		end
	end

	// the chosen source is re-latched while waiting, so a better one can overtake
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			held_idx <= 5'h00;
			held_hi <= 1'b0;
			irq_vector <= `VIH_VEC_BASE;
		end else if (seq != VIH_REQ || (!call_taken && cand_ok)) begin
			held_idx <= cand_idx;
			held_hi <= cand_hi;
			irq_vector <= vec_of(cand_idx);
		end
	end

	// the core takes the call on instruction boundary and acknowledges
	// request drops for one cycle while a better source is latched, so vector and source always agree
	assign irq_req = (seq == VIH_REQ) && cand_ok && (cand_idx == held_idx);
	assign call_taken = irq_ack && irq_req;
	assign irq_src = held_idx;
	assign lv.push = call_taken;
	assign lv.push_high = held_hi;
	assign lv.pop = return_from_isr_instr_done;

	// ***************************************************
	// register read port
	// ***************************************************
	// status shows active levels and sequencer state
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`VIH_OFS_BASIC_EN: reg_rdata <= basic_irq_enable_reg;
				`VIH_OFS_EXT_EN1: reg_rdata <= ext_en1;
				`VIH_OFS_EXT_EN2: reg_rdata <= ext_en2;
				`VIH_OFS_PRIO: reg_rdata <= prio_reg;
				`VIH_OFS_EXT_PRIO1: reg_rdata <= ext_prio1;
				`VIH_OFS_EXT_PRIO2: reg_rdata <= ext_prio2;
				`VIH_OFS_PEND_LO: reg_rdata <= pend[7:0];
				`VIH_OFS_PEND_MID: reg_rdata <= pend[15:8];
				`VIH_OFS_PEND_HI: reg_rdata <= {5'h00, pend[18:16]};
				`VIH_OFS_STATUS: reg_rdata <= {3'h0, seq == VIH_REQ, lv.in_high, lv.in_low, 2'h0};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ***************************************************
	// checks
	// ***************************************************
	// first finished instruction after a return, with no fresh return beside it
	sequence s_return_from_isr_instr_then_instr;
		return_from_isr_instr_done ##[1:2] (instr_done && !return_from_isr_instr_done);
	endsequence

	// an eligible source seen while idle and not just returning
	sequence s_idle_eligible;
		seq == VIH_IDLE && cand_ok && !return_from_isr_instr_done;
	endsequence

	flag_set_a: assert property (@(posedge ref_clk) disable iff (srst)
		src_event[0] |=> pend[0])
		else $error("event did not set pending flag");

	blocked_set_a: assert property (@(posedge ref_clk) disable iff (srst)
		src_event[5] && !global_irq_enable |=> pend[5])
		else $error("event while blocked did not set flag");

	global_block_a: assert property (@(posedge ref_clk) disable iff (srst)
		!global_irq_enable |-> !irq_req)
		else $error("request with global enable low");

	req_cause_a: assert property (@(posedge ref_clk) disable iff (srst)
		irq_req |-> pend[held_idx] && src_en[held_idx] && global_irq_enable)
		else $error("request without enabled pending flag");

	pend_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
		!global_irq_enable && sw_clr == '0 |=> (pend & $past(pend)) == $past(pend))
		else $error("blocked flag lost");

	hw_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		irq_req && irq_ack && held_idx == 5'h00 && !src_event[0] && !reg_wr |=> !pend[0])
		else $error("hardware flag not cleared");

	sw_set_a: assert property (@(posedge ref_clk) disable iff (srst)
		reg_wr && reg_addr == `VIH_OFS_PEND_LO && reg_wdata[1] |=> pend[1])
		else $error("software write did not set flag");

	return_from_isr_instr_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
		return_from_isr_instr_done |=> !irq_req)
		else $error("request before one instruction after return");

	high_noprempt_a: assert property (@(posedge ref_clk) disable iff (srst)
		lv.in_high |-> !irq_req)
		else $error("high routine preempted");

	prio_order_a: assert property (@(posedge ref_clk) disable iff (srst)
		irq_req && |(live & src_hi) |-> src_hi[held_idx])
		else $error("low level served before high");

	vec_match_a: assert property (@(posedge ref_clk) disable iff (srst)
		irq_req |-> irq_vector == vec_of(held_idx))
		else $error("vector does not match source");

	ack_drop_a: assert property (@(posedge ref_clk) disable iff (srst)
		call_taken |=> !irq_req)
		else $error("request still up after the call was taken");

	decode_step_a: assert property (@(posedge ref_clk) disable iff (srst)
		s_idle_eligible |=> seq == VIH_REQ)
		else $error("eligible source not decoded next cycle");

	resume_a: assert property (@(posedge ref_clk) disable iff (srst)
		s_return_from_isr_instr_then_instr |=> seq != VIH_WAIT_ONE)
		else $error("sequencer stuck after return");
endmodule // vih_handler

// >>> vih_lvl_if.sv
// carrier between the handler top and its active-level stack
`timescale 1ns/1ps
interface vih_lvl_if;
	logic push;
	logic push_high;
	logic pop;
	logic in_low;
	logic in_high;
	modport top (output push, output push_high, output pop, input in_low, input in_high);
	modport stk (input push, input push_high, input pop, output in_low, output in_high);
endinterface // vih_lvl_if

// >>> vih_lvl_stack.sv
// two-level record of which service routines are in progress
`timescale 1ns/1ps
module vih_lvl_stack import vih_pkg::*; (
	input wire logic ref_clk,
	input wire logic srst,
	vih_lvl_if.stk lv
);
	logic low_act;
	logic high_act;

	// ***************************************************
	// level tracking
	// ***************************************************
	// a return closes the innermost level, high first; a call taken in the same cycle wins and the return is lost
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_act <= 1'b0;
			high_act <= 1'b0;
		end else if (lv.push) begin
			if (lv.push_high) begin
				high_act <= 1'b1;
			end else begin
				low_act <= 1'b1;
			end
		end else if (lv.pop) begin
			if (high_act) begin
				high_act <= 1'b0;
			end else begin
				low_act <= 1'b0;
			end
		end
	end

	assign lv.in_low = low_act;
	assign lv.in_high = high_act;
endmodule // vih_lvl_stack

// >>> vih_pkg.sv
// types for the vectored interrupt handler
package vih_pkg;
	typedef logic [18:0] vih_src_t;
	typedef logic [4:0] vih_idx_t;
	typedef enum logic [2:0] {
		VIH_IDLE = 3'b001,
		VIH_REQ = 3'b010,
		VIH_WAIT_ONE = 3'b100
	} vih_seq_e;
endpackage
